// ### logic/oss_pkg.sv
package oss_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_RAMP_CFG  = 8'h03;
  localparam logic [7:0] ADDR_ON_DELAY  = 8'h05;
  localparam logic [7:0] ADDR_OFF_DELAY = 8'h06;
  localparam logic [7:0] ADDR_STATUS    = 8'h16;
  // Reset values
  localparam logic [7:0] ON_DELAY_RST   = 8'h00;
  localparam logic [5:0] OFF_DELAY_RST  = 6'h0b;
  localparam logic [2:0] RISE_CODE_RST  = 3'h1;
  localparam logic [2:0] RISE_CODE_TERM = 3'h0;
  localparam logic       FALL_EN_RST    = 1'b1;
  localparam logic [2:0] FALL_CODE_RST  = 3'h4;
  // Ramp configuration field positions
  localparam int RISE_MSB = 6;
  localparam int RISE_LSB = 4;
  localparam int FALL_EN_BIT = 3;
  localparam int FALL_MSB = 2;
  localparam int FALL_LSB = 0;
  // Timebase: both edges of the master clock are counted
  localparam int MCLK_HZ  = 500000;
  localparam int STEP_MV  = 10;
  localparam int EDGES_MS = 2 * MCLK_HZ / 1000;
  localparam logic [17:0] EDGES_PER_MS = 18'(EDGES_MS);
  // Slew rates in mV per ms
  localparam int RATE_0 = 50;
  localparam int RATE_1 = 100;
  localparam int RATE_2 = 200;
  localparam int RATE_3 = 250;
  localparam int RATE_4 = 500;
  localparam int RATE_5 = 1000;
  localparam int RATE_6 = 2000;
  // Master clock edges held per 10 mV step
  localparam logic [7:0] HOLD_0 = 8'(STEP_MV * EDGES_MS / RATE_0);
  localparam logic [7:0] HOLD_1 = 8'(STEP_MV * EDGES_MS / RATE_1);
  localparam logic [7:0] HOLD_2 = 8'(STEP_MV * EDGES_MS / RATE_2);
  localparam logic [7:0] HOLD_3 = 8'(STEP_MV * EDGES_MS / RATE_3);
  localparam logic [7:0] HOLD_4 = 8'(STEP_MV * EDGES_MS / RATE_4);
  localparam logic [7:0] HOLD_5 = 8'(STEP_MV * EDGES_MS / RATE_5);
  localparam logic [7:0] HOLD_6 = 8'(STEP_MV * EDGES_MS / RATE_6);

  // Sequencer states
  typedef enum logic [5:0] {
    ST_OFF   = 6'h01,
    ST_ONDLY = 6'h02,
    ST_RISE  = 6'h04,
    ST_REG   = 6'h08,
    ST_OFDLY = 6'h10,
    ST_FALL  = 6'h20
  } oss_state_t;

  // Step hold for a slew code; reserved codes fall back safely
  function automatic logic [7:0] oss_hold(input logic [2:0] code, input logic rising);
    case (code)
      3'h0: oss_hold = HOLD_0;
      3'h1: oss_hold = HOLD_1;
      3'h2: oss_hold = HOLD_2;
      3'h3: oss_hold = HOLD_3;
      3'h4: oss_hold = HOLD_4;
      3'h5: oss_hold = HOLD_5;
      3'h6: oss_hold = HOLD_6;
      default: oss_hold = rising ? HOLD_0 : HOLD_6;
    endcase
  endfunction
endpackage

// ### logic/oss_sequencer.sv
// How it works
// - After turn-on command, wait the turn-on delay before ramping up.
// - Turn-on delay is eight bits, one ms per count, resets to zero.
// - Turn-off delay ends at zero output with fall ramp, else at switch-off.
// - Slewed turn-off waits delay minus ramp-down time, then ramps down.
// - Without fall ramp, switches simply turn off when the delay expires.
// - Turn-off delay is six bits, resets to 11 ms, top bits read zero.
// - Ramps move the target in 10 mV steps; hold time sets the rate.
// - Step hold time is counted from the manager's master clock.
// - Rising code picks 0.05 to 2.0 V/ms; code 7 reserved; resets to 1.
// - As bus terminator the rising code defaults to 0.
// - Bit 3 enables the controlled fall ramp; resets enabled.
// - Falling code picks -0.05, -0.1, -0.2 V/ms and faster above.
// - Bit 7 of the ramp configuration always reads zero.
// - Overcurrent during the rising ramp trips protection.
// - Pre-biased output: stage stays off until target passes the bias.
`timescale 1ns/1ps
module oss_sequencer #(
  parameter int SP_W = 9
) (
  input  wire logic            clk,
  input  wire logic            rstn,
  input  wire logic            mclk_pin,
  input  wire logic            turn_on_pin,
  input  wire logic            turn_off_pin,
  input  wire logic            terminator_pin,
  input  wire logic            overcurrent_pin,
  input  wire logic [SP_W-1:0] output_setpoint,
  input  wire logic [SP_W-1:0] prebias_level,
  input  wire logic [7:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic      [7:0]      reg_rdata,
  output logic      [SP_W-1:0] ramp_target,
  output logic                 switch_en,
  output logic                 regulating,
  output logic                 ocp_trip
);
  oss_pkg::oss_state_t st_reg, st_next;
  logic [3:0]      s1_reg, s2_reg;
  logic [2:0]      s3_reg;
  logic [1:0]      strap_wait_reg;
  logic [7:0]      on_dly_reg;
  logic [5:0]      off_dly_reg;
  logic [2:0]      rise_code_reg, fall_code_reg;
  logic            fall_en_reg;
  logic            on_pend_reg, off_pend_reg;
  logic [17:0]     cnt_reg, cnt_next;
  logic [SP_W-1:0] tgt_reg, tgt_next;
  logic            sw_reg, sw_next, trip_reg, trip_next;
  logic            regl_reg;
  logic [7:0]      rdata_reg;

  // Pin decode after the synchronisers
  wire       mclk_edge = s2_reg[0] ^ s3_reg[0];
  wire       on_ev     = s2_reg[1] & ~s3_reg[1];
  wire       off_ev    = s2_reg[2] & ~s3_reg[2];
  wire       oc_s      = s2_reg[3];
  wire       wr_cfg    = reg_wr & (reg_addr == oss_pkg::ADDR_RAMP_CFG);
  wire       wr_on     = reg_wr & (reg_addr == oss_pkg::ADDR_ON_DELAY);
  wire       wr_off    = reg_wr & (reg_addr == oss_pkg::ADDR_OFF_DELAY);
  wire [7:0] cfg_rd    = {1'b0, rise_code_reg, fall_en_reg, fall_code_reg};
  wire [7:0] rd_mux    = (reg_addr == oss_pkg::ADDR_RAMP_CFG)  ? cfg_rd :
                         (reg_addr == oss_pkg::ADDR_ON_DELAY)  ? on_dly_reg :
                         (reg_addr == oss_pkg::ADDR_OFF_DELAY) ? {2'b00, off_dly_reg} :
                         (reg_addr == oss_pkg::ADDR_STATUS)    ? {2'b00, st_reg} :
                         8'h00;
  wire [7:0] hold_rise = oss_pkg::oss_hold(rise_code_reg, 1'b1);
  wire [7:0] hold_fall = oss_pkg::oss_hold(fall_code_reg, 1'b0);

  // Delays in master clock edges; pre-ramp wait clamps at zero
  wire [17:0] on_wait   = 18'(on_dly_reg) * oss_pkg::EDGES_PER_MS;
  wire [17:0] off_total = 18'(off_dly_reg) * oss_pkg::EDGES_PER_MS;
  wire [17:0] ramp_down = 18'(tgt_reg) * 18'(hold_fall);
  wire [17:0] pre_ramp  = (off_total > ramp_down) ? (off_total - ramp_down) : 18'h0_0000;
  wire [17:0] off_wait  = fall_en_reg ? pre_ramp : off_total;
  wire        step_done = mclk_edge & (cnt_reg <= 18'h0_0001);
  wire [17:0] cnt_dec   = mclk_edge ? (cnt_reg - 18'h0_0001) : cnt_reg;

  // Synchronisers for the pins, plus delayed copies for edge detect
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_reg <= 4'h0;
      s2_reg <= 4'h0;
      s3_reg <= 3'h0;
    end
    else
    begin
      s1_reg <= {overcurrent_pin, turn_off_pin, turn_on_pin, mclk_pin};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg[2:0];
    end
  end

  // Terminator strap: its own pair of flip-flops, caught once after release
  logic term_s1_reg, term_s2_reg;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      term_s1_reg <= 1'b0;
      term_s2_reg <= 1'b0;
      strap_wait_reg <= 2'h0;
    end
    else
    begin
      term_s1_reg <= terminator_pin;
      term_s2_reg <= term_s1_reg;
      if (strap_wait_reg != 2'h3)
        strap_wait_reg <= strap_wait_reg + 2'h1;
    end
  end

  // Configuration registers, writable at any time
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      on_dly_reg    <= oss_pkg::ON_DELAY_RST;
      off_dly_reg   <= oss_pkg::OFF_DELAY_RST;
      rise_code_reg <= oss_pkg::RISE_CODE_RST;
      fall_en_reg   <= oss_pkg::FALL_EN_RST;
      fall_code_reg <= oss_pkg::FALL_CODE_RST;
    end
    else
    begin
      if (wr_on)
        on_dly_reg <= reg_wdata;
      if (wr_off)
        off_dly_reg <= reg_wdata[5:0];
      if (wr_cfg)
      begin
        rise_code_reg <= reg_wdata[oss_pkg::RISE_MSB:oss_pkg::RISE_LSB];
        fall_en_reg   <= reg_wdata[oss_pkg::FALL_EN_BIT];
        fall_code_reg <= reg_wdata[oss_pkg::FALL_MSB:oss_pkg::FALL_LSB];
      end
      else if (strap_wait_reg == 2'h2 && term_s2_reg)
        rise_code_reg <= oss_pkg::RISE_CODE_TERM;
    end
  end

  // Command latches; a new edge wins over the clear
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      on_pend_reg  <= 1'b0;
      off_pend_reg <= 1'b0;
      rdata_reg    <= 8'h00;
    end
    else
    begin
      on_pend_reg  <= on_ev | (on_pend_reg & (st_reg != oss_pkg::ST_OFF));
      off_pend_reg <= off_ev | (off_pend_reg & (st_reg != oss_pkg::ST_OFF)
                                             & (st_reg != oss_pkg::ST_REG));
      if (reg_rd)
        rdata_reg <= rd_mux;
    end
  end

  // Sequencer next state
  always_comb
  begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    tgt_next  = tgt_reg;
    sw_next   = sw_reg;
    trip_next = trip_reg;
    unique case (st_reg)
      oss_pkg::ST_OFF:
      begin
        sw_next  = 1'b0;
        tgt_next = '0;
        if (on_pend_reg)
        begin
          st_next   = oss_pkg::ST_ONDLY;
          cnt_next  = on_wait;
          trip_next = 1'b0;
        end
      end
      oss_pkg::ST_ONDLY:
      begin
        if (cnt_reg == 18'h0_0000)
        begin
          st_next  = oss_pkg::ST_RISE;
          cnt_next = 18'(hold_rise);
        end
        else
          cnt_next = cnt_dec;
      end
      oss_pkg::ST_RISE:
      begin
        sw_next = tgt_reg > prebias_level;
        if (oc_s)
        begin
          st_next   = oss_pkg::ST_OFF;
          trip_next = 1'b1;
          sw_next   = 1'b0;
        end
        else if (tgt_reg >= output_setpoint)
          st_next = oss_pkg::ST_REG;
        else if (step_done)
        begin
          tgt_next = tgt_reg + 1'b1;
          cnt_next = 18'(hold_rise);
        end
        else
          cnt_next = cnt_dec;
      end
      oss_pkg::ST_REG:
      begin
        sw_next  = 1'b1;
        tgt_next = output_setpoint;
        if (off_pend_reg)
        begin
          st_next  = oss_pkg::ST_OFDLY;
          cnt_next = off_wait;
        end
      end
      oss_pkg::ST_OFDLY:
      begin
        if (cnt_reg != 18'h0_0000)
          cnt_next = cnt_dec;
        else if (fall_en_reg && tgt_reg != '0)
        begin
          st_next  = oss_pkg::ST_FALL;
          cnt_next = 18'(hold_fall);
        end
        else
        begin
          st_next = oss_pkg::ST_OFF;
          sw_next = 1'b0;
        end
      end
      oss_pkg::ST_FALL:
      begin
        if (tgt_reg == '0)
        begin
          st_next = oss_pkg::ST_OFF;
          sw_next = 1'b0;
        end
        else if (step_done)
        begin
          tgt_next = tgt_reg - 1'b1;
          cnt_next = 18'(hold_fall);
        end
        else
          cnt_next = cnt_dec;
      end
      default:
      begin
        st_next = oss_pkg::ST_OFF;
        sw_next = 1'b0;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg   <= oss_pkg::ST_OFF;
      cnt_reg  <= 18'h0_0000;
      tgt_reg  <= '0;
      sw_reg   <= 1'b0;
      trip_reg <= 1'b0;
      regl_reg <= 1'b0;
    end
    else
    begin
      regl_reg <= (st_next == oss_pkg::ST_REG);
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      tgt_reg  <= tgt_next;
      sw_reg   <= sw_next;
      trip_reg <= trip_next;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata   = rdata_reg;
  assign ramp_target = tgt_reg;
  assign switch_en   = sw_reg;
  assign regulating  = regl_reg;
  assign ocp_trip    = trip_reg;

  // Checks
  a_cfg_top_zero: assert property (@(posedge clk) disable iff (!rstn)
    reg_rd && reg_addr == oss_pkg::ADDR_RAMP_CFG |=> !reg_rdata[7])
    else $error("ramp config bit 7 read as one");
  a_off_top_zero: assert property (@(posedge clk) disable iff (!rstn)
    reg_rd && reg_addr == oss_pkg::ADDR_OFF_DELAY |=> reg_rdata[7:6] == 2'b00)
    else $error("turn-off delay top bits read as one");
  a_rise_after_wait: assert property (@(posedge clk) disable iff (!rstn)
    st_reg == oss_pkg::ST_RISE && $past(st_reg) == oss_pkg::ST_ONDLY |->
    $past(cnt_reg) == 18'h0_0000)
    else $error("ramp began before turn-on delay ran out");
  a_step_size: assert property (@(posedge clk) disable iff (!rstn)
    st_reg == oss_pkg::ST_RISE && $past(st_reg) == oss_pkg::ST_RISE &&
    tgt_reg != $past(tgt_reg) |-> tgt_reg == $past(tgt_reg) + 1'b1)
    else $error("rising target moved by other than one step");
  a_step_on_mclk: assert property (@(posedge clk) disable iff (!rstn)
    (st_reg == oss_pkg::ST_FALL) && $past(st_reg) == oss_pkg::ST_FALL &&
    $changed(tgt_reg) |-> $past(mclk_edge))
    else $error("falling step without master clock edge");
  a_prebias_hold: assert property (@(posedge clk) disable iff (!rstn)
    st_reg == oss_pkg::ST_RISE && tgt_reg <= prebias_level |=> !switch_en)
    else $error("stage on below pre-bias level");
  a_ocp_trip: assert property (@(posedge clk) disable iff (!rstn)
    st_reg == oss_pkg::ST_RISE && oc_s |=> ocp_trip && st_reg == oss_pkg::ST_OFF)
    else $error("overcurrent in ramp did not trip");
  a_fall_needs_en: assert property (@(posedge clk) disable iff (!rstn)
    st_reg == oss_pkg::ST_FALL && $past(st_reg) == oss_pkg::ST_OFDLY |->
    $past(fall_en_reg))
    else $error("fall ramp ran while disabled");
  a_reg_order: assert property (@(posedge clk) disable iff (!rstn)
    st_reg == oss_pkg::ST_REG |=> st_reg inside {oss_pkg::ST_REG, oss_pkg::ST_OFDLY})
    else $error("regulating left out of order");
endmodule // oss_sequencer

// ### verification/oss_mgr_model.sv
`timescale 1ns/1ps
// Manager side: shared master clock and command pulses
module oss_mgr_model (
  input  wire logic clk,
  output logic      mclk_pin,
  output logic      turn_on_pin,
  output logic      turn_off_pin
);
  // Idle levels, commands low
  initial
  begin
    mclk_pin = 1'b0;
    turn_on_pin = 1'b0;
    turn_off_pin = 1'b0;
  end

  // Free master clock, sped up so 1 ms spans 1000 short edges
  always #120 mclk_pin = ~mclk_pin;

  // Command pulse held four clocks, long enough for the synchroniser
  task automatic send(input logic on);
    @(negedge clk);
    if (on)
      turn_on_pin = 1'b1;
    else
      turn_off_pin = 1'b1;
    repeat (4) @(negedge clk);
    turn_on_pin = 1'b0;
    turn_off_pin = 1'b0;
  endtask
endmodule // oss_mgr_model

// ### verification/output_sequencing_slew_ctrl_tb.sv
`timescale 1ns/1ps
module output_sequencing_slew_ctrl_tb;
  logic       clk;
  logic       rstn;
  logic       mclk_pin;
  logic       turn_on_pin;
  logic       turn_off_pin;
  logic       terminator_pin;
  logic       overcurrent_pin;
  logic [8:0] output_setpoint;
  logic [8:0] prebias_level;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [8:0] ramp_target;
  logic       switch_en;
  logic       regulating;
  logic       ocp_trip;
  int         mismatches;
  int         n_compared;
  int         n;
  logic [7:0] d;
  int         rate [8] = '{50, 100, 200, 250, 500, 1000, 2000, 50};

  // Device under test and manager model
  oss_sequencer dut_u (
    .clk(clk), .rstn(rstn), .mclk_pin(mclk_pin), .turn_on_pin(turn_on_pin),
    .turn_off_pin(turn_off_pin), .terminator_pin(terminator_pin),
    .overcurrent_pin(overcurrent_pin), .output_setpoint(output_setpoint),
    .prebias_level(prebias_level), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ramp_target(ramp_target),
    .switch_en(switch_en), .regulating(regulating), .ocp_trip(ocp_trip)
  );
  oss_mgr_model mgr_u (
    .clk(clk), .mclk_pin(mclk_pin), .turn_on_pin(turn_on_pin), .turn_off_pin(turn_off_pin)
  );

  // 25 MHz clock
  always #20 clk = ~clk;

  // Register port cycles, launched on falling edges
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask

  // Value and timing comparisons
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_t(input int got, input int exp);
    n_compared++;
    if (got < exp - 12 || got > exp + 12)
    begin
      mismatches++;
      $display("ERROR t=%0t cycles got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    rd(a, d);
    chk8(d, exp);
  endtask

  // Bounded waits, counting clocks into n
  task automatic wait_tgt(input logic [8:0] v);
    n = 0;
    while (ramp_target !== v && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic wait_off();
    n = 0;
    while (switch_en !== 1'b0 && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  // Analog side levels and overcurrent sense
  task automatic set_lv(input logic [8:0] sp, input logic [8:0] pb);
    output_setpoint = sp;
    prebias_level = pb;
  endtask
  task automatic set_oc(input logic v);
    overcurrent_pin = v;
  endtask

  // Reset for four clocks with the strap at the given level
  task automatic rst(input logic strap);
    @(negedge clk);
    rstn = 1'b0;
    terminator_pin = strap;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    repeat (5) @(negedge clk);
  endtask

  // Verdict and end of run
  task automatic finish_test();
    $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial
  begin
    #1000000;
    mismatches++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    terminator_pin = 1'b0;
    set_oc(1'b0);
    set_lv(9'h004, 9'h002);
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    mismatches = 0;
    n_compared = 0;
    rst(1'b0);
    // Reset values, masked bits and an unmapped address
    rdchk(oss_pkg::ADDR_ON_DELAY, 8'h00);
    rdchk(oss_pkg::ADDR_OFF_DELAY, 8'h0b);
    rdchk(oss_pkg::ADDR_RAMP_CFG, 8'h1c);
    wr(oss_pkg::ADDR_OFF_DELAY, 8'hff);
    rdchk(oss_pkg::ADDR_OFF_DELAY, 8'h3f);
    wr(oss_pkg::ADDR_RAMP_CFG, 8'hff);
    rdchk(oss_pkg::ADDR_RAMP_CFG, 8'h7f);
    wr(8'h20, 8'h55);
    rdchk(8'h20, 8'h00);
    // Delayed turn-on, fastest rise into a pre-biased output
    wr(oss_pkg::ADDR_ON_DELAY, 8'h01);
    wr(oss_pkg::ADDR_RAMP_CFG, 8'h68);
    wr(oss_pkg::ADDR_OFF_DELAY, 8'h01);
    mgr_u.send(1'b1);
    rdchk(oss_pkg::ADDR_STATUS, 8'h02);
    wait_tgt(9'h001);
    chk_t(n, 3012);
    wait_tgt(9'h002);
    chk8({7'h00, switch_en}, 8'h00);
    wait_tgt(9'h003);
    chk_t(n, 15);
    repeat (2) @(negedge clk);
    chk8({7'h00, switch_en}, 8'h01);
    wait_tgt(9'h004);
    repeat (3) @(negedge clk);
    chk8({7'h00, regulating}, 8'h01);
    rdchk(oss_pkg::ADDR_STATUS, 8'h08);
    // Slewed turn-off: the four slow steps sit inside the 1 ms delay
    mgr_u.send(1'b0);
    repeat (2696) @(negedge clk);
    rdchk(oss_pkg::ADDR_STATUS, 8'h20);
    chk8(ramp_target[7:0], 8'h01);
    wait_off();
    chk_t(n, 305);
    chk8(ramp_target[7:0], 8'h00);
    // Fall ramp disabled: target holds until the switches open
    wr(oss_pkg::ADDR_ON_DELAY, 8'h00);
    wr(oss_pkg::ADDR_RAMP_CFG, 8'h60);
    mgr_u.send(1'b1);
    wait_tgt(9'h004);
    repeat (3) @(negedge clk);
    mgr_u.send(1'b0);
    repeat (2698) @(negedge clk);
    chk8(ramp_target[7:0], 8'h04);
    wait_off();
    chk_t(n, 305);
    // Every rise code, reserved code 7 at the slowest rate
    wr(oss_pkg::ADDR_OFF_DELAY, 8'h00);
    set_lv(9'h002, 9'h000);
    for (int c = 0; c < 8; c++)
    begin
      wr(oss_pkg::ADDR_RAMP_CFG, {1'b0, 3'(c), 4'h0});
      mgr_u.send(1'b1);
      wait_tgt(9'h001);
      wait_tgt(9'h002);
      chk_t(n, 10000 / rate[c] * 3);
      mgr_u.send(1'b0);
      wait_off();
    end
    // Overcurrent in mid-rise trips the stage; next turn-on clears it
    wr(oss_pkg::ADDR_RAMP_CFG, 8'h00);
    mgr_u.send(1'b1);
    wait_tgt(9'h001);
    set_oc(1'b1);
    repeat (6) @(negedge clk);
    chk8({6'h00, ocp_trip, switch_en}, 8'h02);
    rdchk(oss_pkg::ADDR_STATUS, 8'h01);
    set_oc(1'b0);
    repeat (4) @(negedge clk);
    mgr_u.send(1'b1);
    repeat (4) @(negedge clk);
    chk8({7'h00, ocp_trip}, 8'h00);
    // Terminator strap selects the slowest rise default
    rst(1'b1);
    rdchk(oss_pkg::ADDR_RAMP_CFG, 8'h0c);
    finish_test();
  end
endmodule // output_sequencing_slew_ctrl_tb
